// ===== rtl/chm_pkg.sv
// Purpose: shared constants, types and a reference product for the hard multiplier block
// Assumes: operands arrive from fabric logic clocked by sys_clk
// Notes: the reference function serves the embedded assertions only
//
// Functional notes
// - The block works either as one 18x18 multiplier or as two independent 9x9 multipliers.
// - In wide mode operands of 10 to 18 bits are accepted and the full product is produced.
// - In dual mode two separate products are formed at once, each from operands of up to 9 bits.
// - Operands are taken in 9-bit or 18-bit slices, each slice registered or fed straight through.
// - Operand A and operand B each have their own register-or-bypass choice.
// - All input and output registers share one clock, one clock enable and one async clear.
// - A high operand A sign control means A is two's complement, low means unsigned.
// - The operand B sign control treats operand B the same way.
// - The product is signed when at least one operand is signed, else unsigned.
// - There is one A and one B sign control, and both dual-mode multipliers use them.
// - The sign controls may change from cycle to cycle while running.
// - The sign controls have their own optional input register to line up with operands.
// - The product keeps full precision with no truncation for every sign combination.
// - The product may pass through output registers in 18-bit or 36-bit slices.
// - With the sign controls unconnected the block multiplies both operands as unsigned.
package chm_pkg;
    localparam int CHM_WIDE_W = 18;
    localparam int CHM_NARROW_W = 9;
    localparam int CHM_PROD_W = 36;
    localparam int CHM_SLICE_W = 18;
    localparam logic CHM_REG_RESET = 1'h0;

    typedef enum logic {CHM_WIDE, CHM_DUAL} chm_mode_t;

    function automatic logic [35:0] chm_ref(input logic [17:0] a, input logic [17:0] b,
                                            input logic sa, input logic sb,
                                            input logic dual);
        logic signed [37:0] w;
        logic signed [19:0] l;
        logic signed [19:0] h;
        w = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
        l = $signed({sa & a[8], a[8:0]}) * $signed({sb & b[8], b[8:0]});
        h = $signed({sa & a[17], a[17:9]}) * $signed({sb & b[17], b[17:9]});
        chm_ref = dual ? {h[17:0], l[17:0]} : w[35:0];
    endfunction
endpackage

// ===== rtl/chm_reg.sv
// Purpose: one register slice with shared enable and async clear
// Assumes: aclr is the block's own clear, rst_n the system reset
// Notes: clear takes priority over enable
module chm_reg
    import chm_pkg::*;
#(
    parameter int W = 9
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic aclr,
    input wire logic ena,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    if (W < 1) begin : g_bad_width
        $error("chm_reg width must be at least one");
    end

    always_ff @(posedge sys_clk or posedge aclr) begin
        if (aclr) begin
            q <= {W{CHM_REG_RESET}};
        end else if (!rst_n) begin
            q <= {W{CHM_REG_RESET}};
        end else if (ena) begin
            q <= d;
        end
    end
endmodule

// ===== rtl/chm_smul.sv
// Purpose: W by W multiplier with per-operand sign selection
// Assumes: sa and sb are stable while the product is used
// Notes: one guard bit per operand keeps every sign mix exact
module chm_smul
    import chm_pkg::*;
#(
    parameter int W = 9
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic sa,
    input wire logic sb,
    output logic [2*W-1:0] p
);
    if (W < 2) begin : g_bad_width
        $error("chm_smul width must be at least two");
    end

    logic signed [W:0] a_ext;
    logic signed [W:0] b_ext;
    logic signed [2*W+1:0] full;

    // a low sign control pads with zero, so the operand reads as unsigned
    assign a_ext = $signed({sa & a[W-1], a});
    assign b_ext = $signed({sb & b[W-1], b});
    assign full = a_ext * b_ext;
    // the true product always fits in 2W bits, so the guard bits carry nothing
    assign p = full[2*W-1:0];
endmodule

// ===== rtl/chm_top.sv
// Purpose: hard multiplier block, one 18x18 or two 9x9 products
// Assumes: config ports are static or change only with care; fabric on sys_clk
// Notes: bypassed paths are combinational from operand to result
module chm_top
    import chm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic aclr,
    input wire logic ena,
    input wire logic mode_dual,
    input wire logic reg_a_en,
    input wire logic reg_b_en,
    input wire logic reg_sign_en,
    input wire logic reg_out_en,
    input wire logic sign_used,
    input wire logic signa,
    input wire logic signb,
    input wire logic [17:0] data_a,
    input wire logic [17:0] data_b,
    output logic [35:0] result,
    output logic result_signed
);
    chm_mode_t mode;
    logic [8:0] a_q_lo;
    logic [8:0] a_q_hi;
    logic [8:0] b_q_lo;
    logic [8:0] b_q_hi;
    logic [1:0] sign_raw;
    logic [1:0] sign_q;
    logic [1:0] sign_eff;
    logic [17:0] a_eff;
    logic [17:0] b_eff;
    logic [35:0] wide_p;
    logic [17:0] lo_p;
    logic [17:0] hi_p;
    logic [35:0] prod_mux;
    logic prod_signed;
    logic [17:0] out_lo_q;
    logic [17:0] out_hi_q;
    logic sgn_out_q;
    logic all_bypass;

    assign mode = mode_dual ? CHM_DUAL : CHM_WIDE;

    // operand input registers, in 9-bit slices so both modes share them
    chm_reg #(.W(CHM_NARROW_W)) u_a_lo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .aclr(aclr),
        .ena(ena),
        .d(data_a[8:0]),
        .q(a_q_lo)
    );
    chm_reg #(.W(CHM_NARROW_W)) u_a_hi (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .aclr(aclr),
        .ena(ena),
        .d(data_a[17:9]),
        .q(a_q_hi)
    );
    chm_reg #(.W(CHM_NARROW_W)) u_b_lo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .aclr(aclr),
        .ena(ena),
        .d(data_b[8:0]),
        .q(b_q_lo)
    );
    chm_reg #(.W(CHM_NARROW_W)) u_b_hi (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .aclr(aclr),
        .ena(ena),
        .d(data_b[17:9]),
        .q(b_q_hi)
    );

    // each operand picks its own path
    assign a_eff = reg_a_en ? {a_q_hi, a_q_lo} : data_a;
    assign b_eff = reg_b_en ? {b_q_hi, b_q_lo} : data_b;

    // unconnected sign controls fall back to unsigned
    assign sign_raw = sign_used ? {signa, signb} : 2'h0;

    chm_reg #(.W(2)) u_sign (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .aclr(aclr),
        .ena(ena),
        .d(sign_raw),
        .q(sign_q)
    );
    assign sign_eff = reg_sign_en ? sign_q : sign_raw;

    // both products are always formed; only one set reaches the result
    chm_smul #(.W(CHM_WIDE_W)) u_wide (
        .a(a_eff),
        .b(b_eff),
        .sa(sign_eff[1]),
        .sb(sign_eff[0]),
        .p(wide_p)
    );
    // one sign pair feeds both narrow halves, so mixed halves cannot be expressed
    chm_smul #(.W(CHM_NARROW_W)) u_lo (
        .a(a_eff[8:0]),
        .b(b_eff[8:0]),
        .sa(sign_eff[1]),
        .sb(sign_eff[0]),
        .p(lo_p)
    );
    chm_smul #(.W(CHM_NARROW_W)) u_hi (
        .a(a_eff[17:9]),
        .b(b_eff[17:9]),
        .sa(sign_eff[1]),
        .sb(sign_eff[0]),
        .p(hi_p)
    );

    assign prod_mux = (mode == CHM_DUAL) ? {hi_p, lo_p} : wide_p;
    assign prod_signed = sign_eff[1] | sign_eff[0];

    // output registers in 18-bit slices; in wide mode both act as one 36-bit word
    chm_reg #(.W(CHM_SLICE_W)) u_out_lo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .aclr(aclr),
        .ena(ena),
        .d(prod_mux[17:0]),
        .q(out_lo_q)
    );
    chm_reg #(.W(CHM_SLICE_W)) u_out_hi (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .aclr(aclr),
        .ena(ena),
        .d(prod_mux[35:18]),
        .q(out_hi_q)
    );
    chm_reg #(.W(1)) u_out_sgn (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .aclr(aclr),
        .ena(ena),
        .d(prod_signed),
        .q(sgn_out_q)
    );

    assign result = reg_out_en ? {out_hi_q, out_lo_q} : prod_mux;
    assign result_signed = reg_out_en ? sgn_out_q : prod_signed;

    assign all_bypass = !reg_a_en && !reg_b_en && !reg_sign_en && !reg_out_en;

    default clocking chm_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n || aclr);

    wide_path_a: assert property (all_bypass && !mode_dual |->
        result == chm_ref(data_a, data_b, sign_raw[1], sign_raw[0], 1'h0))
        else $error("wide product does not match operands");

    dual_path_a: assert property (all_bypass && mode_dual |->
        result == chm_ref(data_a, data_b, sign_raw[1], sign_raw[0], 1'h1))
        else $error("dual products do not match operands");

    lane_split_a: assert property (mode_dual && !reg_out_en && a_eff[8:0] == 9'h000 |->
        result[17:0] == 18'h00000)
        else $error("high lane leaked into low product");

    full_prec_a: assert property (all_bypass && !mode_dual && sign_used && signa && signb &&
        data_a == 18'h20000 && data_b == 18'h20000 |-> result == 36'h400000000)
        else $error("most negative square lost precision");

    a_only_reg_a: assert property (reg_a_en && !reg_b_en && !reg_sign_en && !reg_out_en &&
        !mode_dual && ena ##1 (reg_a_en && !reg_b_en && !reg_sign_en && !reg_out_en &&
        !mode_dual) |-> result == chm_ref($past(data_a), data_b, sign_raw[1],
        sign_raw[0], 1'h0))
        else $error("registered A with direct B gave wrong product");

    opnd_reg_a: assert property (ena |=> {a_q_hi, a_q_lo, b_q_hi, b_q_lo} ==
        $past({data_a, data_b}))
        else $error("operand slices did not capture");

    hold_regs_a: assert property (!ena |=> $stable({a_q_hi, a_q_lo, b_q_hi, b_q_lo,
        sign_q, out_hi_q, out_lo_q, sgn_out_q}))
        else $error("registers moved while enable was low");

    clear_zero_a: assert property (disable iff (!rst_n) aclr |-> {a_q_hi, a_q_lo, b_q_hi,
        b_q_lo, sign_q, out_hi_q, out_lo_q, sgn_out_q} == 0)
        else $error("clear left a register nonzero");

    sign_reg_a: assert property (reg_sign_en && ena ##1 reg_sign_en |->
        sign_eff == $past(sign_raw))
        else $error("registered sign controls out of step");

    sign_live_a: assert property (!reg_sign_en && !reg_out_en |->
        result_signed == (sign_used && (signa || signb)))
        else $error("result sign flag wrong");

    sign_dflt_a: assert property (all_bypass && !sign_used |-> !result_signed &&
        result == chm_ref(data_a, data_b, 1'h0, 1'h0, mode_dual))
        else $error("unconnected signs not unsigned");

    out_reg_a: assert property (reg_out_en && ena ##1 reg_out_en |->
        result == $past(prod_mux) && result_signed == $past(prod_signed))
        else $error("output register did not follow product");

    dual_mixed_c: cover property (all_bypass && mode_dual && sign_used && signa && !signb);
    wide_signed_c: cover property (all_bypass && !mode_dual && sign_used && signa && signb);
    piped_c: cover property (reg_a_en && reg_b_en && reg_sign_en && reg_out_en && ena [*3]);
    clear_c: cover property (disable iff (!rst_n) aclr ##1 !aclr);
endmodule

// ===== sim/chm_fabric.sv
// Purpose: fabric-side operand source for the hard multiplier
// Assumes: one sign pair serves both narrow halves
// Notes: operands narrower than 18 bits are extended here, the block does not do it
module chm_fabric (
    input wire logic [17:0] op_a,
    input wire logic [17:0] op_b,
    input wire logic [4:0] op_w,
    input wire logic sa_in,
    input wire logic sb_in,
    output logic [17:0] data_a,
    output logic [17:0] data_b,
    output logic signa,
    output logic signb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] keep;
    assign keep = (18'h00001 << op_w) - 18'h00001;
    // one sign pair feeds both halves, so their signedness cannot differ
    assign signa = sa_in;
    assign signb = sb_in;
    assign data_a = (op_a & keep) | ((sa_in && op_a[op_w - 1]) ? ~keep : 18'h00000);
    assign data_b = (op_b & keep) | ((sb_in && op_b[op_w - 1]) ? ~keep : 18'h00000);
endmodule

// ===== sim/tb_top.sv
// Purpose: self-checking bench for the hard multiplier block
// Assumes: inputs change at the falling edge of sys_clk
// Notes: expected products come from a local model, not from the package
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, aclr = 0, ena = 1, mode_dual = 0, sign_used = 1;
    logic reg_a_en = 0, reg_b_en = 0, reg_sign_en = 0, reg_out_en = 0, sa = 0, sb = 0;
    logic [17:0] op_a = 0, op_b = 0;
    logic [4:0] op_w = 5'h12;
    wire [17:0] data_a, data_b;
    wire signa, signb, result_signed;
    wire [35:0] result;
    int err_total = 0, checks_done = 0, cyc = 0;

    chm_fabric chm_fabric_i (.op_a(op_a), .op_b(op_b), .op_w(op_w), .sa_in(sa), .sb_in(sb),
        .data_a(data_a), .data_b(data_b), .signa(signa), .signb(signb));
    chm_top chm_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .aclr(aclr), .ena(ena),
        .mode_dual(mode_dual), .reg_a_en(reg_a_en), .reg_b_en(reg_b_en),
        .reg_sign_en(reg_sign_en), .reg_out_en(reg_out_en), .sign_used(sign_used),
        .signa(signa), .signb(signb), .data_a(data_a), .data_b(data_b), .result(result),
        .result_signed(result_signed));

    always #4 sys_clk = ~sys_clk;
    // the whole run needs well under 200 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            $display("[FAIL] %0t timeout", $time);
            wrap_up();
        end
    end

    function automatic longint ext(logic [17:0] v, int w, logic s);
        longint m;
        m = (longint'(1) << w) - 1;
        ext = longint'(v) & m;
        if (s && v[w-1]) ext = ext - m - 1;
    endfunction

    function automatic logic [35:0] prod(logic [17:0] a, logic [17:0] b, logic ga, logic gb,
                                         logic d);
        longint lo, hi;
        if (!d) return 36'(ext(a, 18, ga) * ext(b, 18, gb));
        lo = ext(a, 9, ga) * ext(b, 9, gb);
        hi = ext(a >> 9, 9, ga) * ext(b >> 9, 9, gb);
        return {hi[17:0], lo[17:0]};
    endfunction

    task chk(input logic [35:0] e, input logic es, input string what);
        checks_done++;
        if (result !== e || result_signed !== es) begin
            err_total++;
            $display("[FAIL] %0t %s got %h/%b want %h/%b", $time, what, result, result_signed,
                     e, es);
        end
    endtask

    task cfg(input logic [3:0] r, input logic d);
        @(negedge sys_clk);
        {reg_a_en, reg_b_en, reg_sign_en, reg_out_en} = r;
        mode_dual = d;
    endtask

    // every sign mix, all paths bypassed, so results are checked in the same cycle
    task t_comb(input logic [17:0] a, input logic [17:0] b, input logic d, input string n);
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            {sa, sb} = i[1:0];
            op_a = a;
            op_b = b;
            #1;
            chk(prod(18'(ext(a, op_w, sa)), 18'(ext(b, op_w, sb)), sa, sb, d), sa | sb, n);
        end
        $display("test %s done", n);
    endtask

    task t_unused;
        @(negedge sys_clk);
        sign_used = 0;
        {sa, sb} = 2'h3;
        op_a = 18'h3FFFF;
        op_b = 18'h20000;
        #1;
        chk(prod(op_a, op_b, 0, 0, 0), 1'h0, "unused");
        // keep the controls unconnected across one edge so the embedded check sees it
        @(negedge sys_clk);
        sign_used = 1;
        $display("test unused done");
    endtask

    // all registers on, signs toggled every cycle: two cycles of latency
    task t_pipe;
        logic [35:0] e[4];
        logic es[4];
        cfg(4'hF, 0);
        for (int i = 0; i < 6; i++) begin
            if (i < 4) begin
                op_a = 18'h3FFF0 + 18'(i);
                op_b = 18'h20123;
                {sa, sb} = {i[0], ~i[0]};
                e[i] = prod(op_a, op_b, sa, sb, 0);
                es[i] = 1'h1;
            end
            if (i >= 2) begin
                #1;
                chk(e[i-2], es[i-2], "pipe");
            end
            @(negedge sys_clk);
        end
        $display("test pipe done");
    endtask

    // operand A registered, operand B straight through
    task t_split;
        cfg(4'h8, 0);
        {sa, sb} = 2'h0;
        op_a = 18'h00005;
        op_b = 18'h00003;
        @(negedge sys_clk);
        op_b = 18'h00007;
        op_a = 18'h00009;
        #1;
        chk(36'h00000023, 1'h0, "split");
        @(negedge sys_clk);
        #1;
        chk(36'h0000003F, 1'h0, "split");
        $display("test split done");
    endtask

    task t_hold;
        cfg(4'hF, 0);
        op_a = 18'h00003;
        op_b = 18'h00004;
        repeat (2) @(negedge sys_clk);
        ena = 0;
        op_a = 18'h00005;
        repeat (3) @(negedge sys_clk);
        chk(36'h0000000C, 1'h0, "hold");
        aclr = 1;
        #1;
        chk(36'h000000000, 1'h0, "clear");
        @(negedge sys_clk);
        aclr = 0;
        ena = 1;
        $display("test hold done");
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge sys_clk);
        rst_n = 1;
        t_comb(18'h20000, 18'h3FFFF, 0, "wide");
        t_comb(18'h20000, 18'h20000, 0, "square");
        op_w = 5'h0A;
        t_comb(18'h00200, 18'h003FF, 0, "narrow");
        op_w = 5'h12;
        cfg(4'h0, 1);
        t_comb({9'h100, 9'h1FF}, {9'h1FF, 9'h003}, 1, "dual");
        t_comb({9'h1FF, 9'h000}, {9'h0AB, 9'h1C5}, 1, "lanes");
        cfg(4'h0, 0);
        t_unused();
        t_pipe();
        t_split();
        t_hold();
        wrap_up();
    end
endmodule
